// file: tcsb_defines.svh
// register offsets, field positions, reset values and timing counts of the config bank
`ifndef TCSB_DEFINES_SVH
`define TCSB_DEFINES_SVH
`define TCSB_ADDR_RT0 5'h00
`define TCSB_ADDR_RT1 5'h01
`define TCSB_ADDR_FS0 5'h02
`define TCSB_ADDR_LOH 5'h03
`define TCSB_ADDR_LOL 5'h04
`define TCSB_ADDR_STAT 5'h05
`define TCSB_RST_BYTE 8'h00
`define TCSB_RST_BAND 2'h1
`define TCSB_BIT_RX_MODE 7
`define TCSB_BIT_REF_SRC 7
`define TCSB_BIT_WAKEUP 6
`define TCSB_BIT_PREFILT 5
`define TCSB_BIT_FE_SRC 4
`define TCSB_BIT_EDGE 3
`define TCSB_BIT_MOD_INH 2
`define TCSB_BIT_RANGE 1
`define TCSB_BIT_CLKOUT 0
`define TCSB_CNT_ADDR_END 5'd6
`define TCSB_CNT_DATA_END 5'd14
`define TCSB_CNT_STOP_END 5'd16
`define TCSB_CNT_READ_END 5'd14
`endif

// file: tcsb_pkg.sv
// types shared by the config bank modules
package tcsb_pkg;
    typedef enum logic [1:0] {
        TCSB_IDLE = 2'b00,
        TCSB_WRITE = 2'b01,
        TCSB_READ = 2'b10,
        TCSB_WAIT = 2'b11
    } tcsb_state_e;
    typedef logic [7:0] tcsb_byte_t;
endpackage : tcsb_pkg

// file: tcsb_sync.sv
// two-flop synchroniser with edge pulses for the serial pins
`timescale 1ns/100ps
`default_nettype none
module tcsb_sync #(
    parameter int WIDTH = 3
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall
);
    logic [WIDTH-1:0] meta_reg; // first stage, read only by second
    logic [WIDTH-1:0] sync_reg; // settled level
    logic [WIDTH-1:0] prev_reg; // level one cycle back for edges

    // chain of three flops; resets to idle-high as the bus rests high
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            meta_reg <= {WIDTH{1'b1}};
            sync_reg <= {WIDTH{1'b1}};
            prev_reg <= {WIDTH{1'b1}};
        end else if (i_ce) begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // edge pulses are gated by the enable so they last one active cycle
    assign o_level = sync_reg;
    assign o_rise = (sync_reg & ~prev_reg) & {WIDTH{i_ce}};
    assign o_fall = (~sync_reg & prev_reg) & {WIDTH{i_ce}};
endmodule : tcsb_sync
`default_nettype wire

// file: tcsb_bank.sv
// serial-programmed configuration and status byte bank of the transceiver
`timescale 1ns/100ps
`default_nettype none
`include "tcsb_defines.svh"
module tcsb_bank
    import tcsb_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_en,
    output logic o_so,
    input wire logic [1:0] i_strength_level,
    input wire logic [7:0] i_freq_error_count,
    input wire logic [1:0] i_freq_error_corr,
    input wire logic i_strength_active,
    output logic o_rx_mode_select,
    output logic [1:0] o_baseband_bandwidth,
    output logic [1:0] o_tx_power_level,
    output logic o_ref_source_select,
    output logic o_rx_wakeup_type,
    output logic o_tx_prefilter_enable,
    output logic o_freq_error_source,
    output logic o_tx_edge_time,
    output logic o_tx_modulation_inhibit,
    output logic o_strength_range,
    output logic o_clock_out_enable,
    output logic [1:0] o_band_select,
    output logic [2:0] o_fsk_deviation,
    output logic [2:0] o_bit_rate_select,
    output logic signed [15:0] o_lo_offset,
    output logic o_band_invalid,
    output logic o_rate_invalid,
    output logic [7:0] o_rx_tx_params_0,
    output logic [7:0] o_synth_other
);
    // synchronised pins
    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic sck_rise;
    logic sck_fall;
    logic si_level;
    logic en_level;
    logic en_rise;

    // frame engine
    tcsb_state_e state_reg;
    tcsb_state_e state_next;
    logic [4:0] bit_cnt_reg; // bits taken since the start bit
    logic [4:0] addr_reg; // address shifted in msb first
    logic [7:0] data_reg; // write data shifted in msb first
    logic [7:0] rd_shift_reg; // read byte shifted out msb first
    logic so_reg; // serial output flop
    logic stop_ok_reg; // first stop bit seen as one
    logic [4:0] bit_cnt_inc;

    // staging and live banks; no entry 5 since status is read only
    tcsb_byte_t stage_reg [0:4];
    tcsb_byte_t live_reg [0:4];
    logic [4:0] stage_dirty_reg; // bytes written since last enable rise

    // status byte, read byte and frame decode signals
    tcsb_byte_t status_byte;
    tcsb_byte_t rd_byte;
    logic addr_in_bank;
    logic write_commit;
    logic frame_start;

    tcsb_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_async({i_en, i_si, i_sck}),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    // named views of the synchronised pins
    assign sck_rise = pin_rise[0];
    assign sck_fall = pin_fall[0];
    assign si_level = pin_level[1];
    assign en_level = pin_level[2];
    assign en_rise = pin_rise[2];
    assign bit_cnt_inc = bit_cnt_reg + 5'd1;

    // start condition: si low on a falling sck edge while enable low
    assign frame_start = (state_reg == TCSB_IDLE) && sck_fall && !si_level && !en_level;

    // write lands only after the last data bit and a good first stop
    assign write_commit = (state_reg == TCSB_WRITE) && sck_fall && si_level && stop_ok_reg
        && (bit_cnt_reg == `TCSB_CNT_STOP_END - 5'd1);
    assign addr_in_bank = (addr_reg < `TCSB_ADDR_STAT);

    // status byte: the error source picks which result layout is shown
    always_comb begin
        status_byte = `TCSB_RST_BYTE;
        if (!live_reg[1][`TCSB_BIT_FE_SRC]) begin
            status_byte = i_freq_error_count;
        end else begin
            status_byte[5:4] = i_freq_error_corr;
        end
        if (i_strength_active) begin
            status_byte[7:6] = i_strength_level;
        end
    end

    // read mux: staged bytes are not visible; reading returns live settings
    always_comb begin
        rd_byte = `TCSB_RST_BYTE;
        if (addr_reg == `TCSB_ADDR_STAT) begin
            rd_byte = status_byte;
        end else if (addr_in_bank) begin
            rd_byte = live_reg[addr_reg[2:0]];
        end
    end

    // frame sequencing state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TCSB_IDLE: begin
                if (frame_start) begin
                    state_next = TCSB_WRITE; // direction decided on next bit
                end
            end
            TCSB_WRITE: begin
                if (en_level) begin
                    state_next = TCSB_IDLE; // enable high aborts the frame
                end else if (sck_fall && bit_cnt_reg == 5'd0 && si_level) begin
                    state_next = TCSB_READ;
                end else if (sck_fall && bit_cnt_reg == `TCSB_CNT_STOP_END - 5'd1) begin
                    state_next = TCSB_WAIT;
                end
            end
            TCSB_READ: begin
                if (en_level) begin
                    state_next = TCSB_IDLE;
                end else if (sck_fall && bit_cnt_reg == `TCSB_CNT_READ_END - 5'd1) begin
                    state_next = TCSB_WAIT;
                end
            end
            TCSB_WAIT: begin
                // one falling sck with si high, or enable high, is needed before a new start
                if (en_level || (sck_fall && si_level)) begin
                    state_next = TCSB_IDLE;
                end
            end
            default: begin
                state_next = TCSB_IDLE;
            end
        endcase
    end

    // state and bit counter
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_reg <= TCSB_IDLE;
            bit_cnt_reg <= 5'd0;
        end else if (i_ce) begin
            state_reg <= state_next;
            if (state_reg == TCSB_IDLE) begin
                bit_cnt_reg <= 5'd0;
            end else if (sck_fall) begin
                bit_cnt_reg <= bit_cnt_inc;
            end
        end
    end

    // sample address, data and stop bit on falling sck
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            addr_reg <= 5'h00;
            data_reg <= 8'h00;
            stop_ok_reg <= 1'b0;
        end else if (i_ce && sck_fall && state_reg != TCSB_IDLE) begin
            if (bit_cnt_reg >= 5'd1 && bit_cnt_reg <= `TCSB_CNT_ADDR_END - 5'd1
                    && state_reg != TCSB_WAIT) begin
                addr_reg <= {addr_reg[3:0], si_level};
            end
            if (state_reg == TCSB_WRITE && bit_cnt_reg >= `TCSB_CNT_ADDR_END
                    && bit_cnt_reg <= `TCSB_CNT_DATA_END - 5'd1) begin
                data_reg <= {data_reg[6:0], si_level};
            end
            if (bit_cnt_reg == `TCSB_CNT_DATA_END) begin
                stop_ok_reg <= si_level;
            end
        end
    end

    // serial output: load after the last address bit, shift on rising sck
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rd_shift_reg <= 8'h00;
            so_reg <= 1'b0;
        end else if (i_ce) begin
            if (state_reg != TCSB_READ) begin
                so_reg <= 1'b0; // outside read mode the output rests low
                rd_shift_reg <= 8'h00;
            end else if (sck_fall && bit_cnt_reg == `TCSB_CNT_ADDR_END - 5'd1) begin
                // address completes now; the byte is loaded on the next rising sck
                rd_shift_reg <= 8'h00;
            end else if (sck_rise && bit_cnt_reg == `TCSB_CNT_ADDR_END) begin
                so_reg <= rd_byte[7];
                rd_shift_reg <= {rd_byte[6:0], 1'b0};
            end else if (sck_rise && bit_cnt_reg > `TCSB_CNT_ADDR_END) begin
                so_reg <= rd_shift_reg[7];
                rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
            end
        end
    end

    // staging and live copies, one generate entry per writable byte
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_byte
            logic hit;
            assign hit = write_commit && addr_in_bank && (addr_reg == 5'(gi));
            always_ff @(posedge i_clk_sys) begin
                if (i_srst) begin
                    stage_reg[gi] <= (gi == 2) ? {`TCSB_RST_BAND, 6'h00} : `TCSB_RST_BYTE;
                    live_reg[gi] <= (gi == 2) ? {`TCSB_RST_BAND, 6'h00} : `TCSB_RST_BYTE;
                    stage_dirty_reg[gi] <= 1'b0;
                end else if (i_ce) begin
                    if (hit) begin
                        stage_reg[gi] <= data_reg;
                    end
                    // a write in the same cycle as the enable rise stays pending
                    if (en_rise && stage_dirty_reg[gi]) begin
                        live_reg[gi] <= stage_reg[gi];
                    end
                    if (hit) begin
                        stage_dirty_reg[gi] <= 1'b1;
                    end else if (en_rise) begin
                        stage_dirty_reg[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // live field decode; o_synth_other shows the staged byte 2
    assign o_so = so_reg;
    assign o_rx_tx_params_0 = live_reg[0];
    assign o_rx_mode_select = live_reg[0][`TCSB_BIT_RX_MODE];
    assign o_baseband_bandwidth = live_reg[0][3:2];
    assign o_tx_power_level = live_reg[0][1:0];
    assign o_ref_source_select = live_reg[1][`TCSB_BIT_REF_SRC];
    assign o_rx_wakeup_type = live_reg[1][`TCSB_BIT_WAKEUP];
    assign o_tx_prefilter_enable = live_reg[1][`TCSB_BIT_PREFILT];
    assign o_freq_error_source = live_reg[1][`TCSB_BIT_FE_SRC];
    // edge time only matters with prefiltering; forced low otherwise
    assign o_tx_edge_time = live_reg[1][`TCSB_BIT_EDGE] & live_reg[1][`TCSB_BIT_PREFILT];
    assign o_tx_modulation_inhibit = live_reg[1][`TCSB_BIT_MOD_INH];
    assign o_strength_range = live_reg[1][`TCSB_BIT_RANGE];
    assign o_clock_out_enable = live_reg[1][`TCSB_BIT_CLKOUT];
    assign o_band_select = live_reg[2][7:6];
    assign o_band_invalid = (live_reg[2][7:6] == 2'h0);
    assign o_fsk_deviation = live_reg[2][5:3];
    assign o_bit_rate_select = live_reg[2][2:0];
    assign o_rate_invalid = (live_reg[2][2:0] > 3'h4);
    // signed offset in 500 Hz units around the band centre
    assign o_lo_offset = {live_reg[3], live_reg[4]};
    assign o_synth_other = stage_reg[2];
endmodule : tcsb_bank
`default_nettype wire

// file: tcsb_host.sv
// host-side serial master model that drives the config bank pins
`timescale 1ns/100ps
`default_nettype none
module tcsb_host #(
    parameter int HP = 6 // system cycles per serial clock half period
) (
    input wire logic i_clk_sys,
    input wire logic i_so,
    output logic o_sck,
    output logic o_si,
    output logic o_en,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data
);
    // pins start high and sck and si rest high between frames, so the bank sees no stray edges
    initial begin
        o_sck = 1'b1;
        o_si = 1'b1;
        o_en = 1'b1;
        o_rd_valid = 1'b0;
        o_rd_data = 8'h00;
    end
    // wait n system edges, then step just off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : tick
    // data set while sck is high, read bit sampled just before the fall
    task automatic send_bit(input logic b, output logic s);
        o_si = b;
        tick(HP);
        s = i_so;
        o_sck = 1'b0;
        tick(HP);
        o_sck = 1'b1;
    endtask : send_bit
    // one whole frame; bad_stop spoils the first stop bit on purpose
    task automatic frame(input logic rw, input logic [4:0] addr, input logic [7:0] data,
            input logic bad_stop);
        logic s;
        logic [7:0] sh;
        o_en = 1'b0; // enable stays low for the whole frame
        tick(HP);
        send_bit(1'b0, s);
        send_bit(rw, s);
        for (int i = 4; i >= 0; i--) send_bit(addr[i], s);
        // read bits come out on rises, so si just rests high meanwhile
        for (int i = 7; i >= 0; i--) begin
            send_bit(rw ? 1'b1 : data[i], s);
            sh[i] = s;
        end
        if (!rw) begin
            send_bit(~bad_stop, s);
            send_bit(1'b1, s);
        end
        send_bit(1'b1, s); // one idle fall before any next start
        if (rw) begin
            o_rd_data = sh;
            o_rd_valid = 1'b1;
            tick(1);
            o_rd_valid = 1'b0;
        end
    endtask : frame
    // rising enable hands the staged bytes to the live settings
    task automatic commit();
        o_en = 1'b1;
        tick(30);
    endtask : commit
endmodule : tcsb_host
`default_nettype wire

// file: tcsb_bank_asserts.sv
// concurrent checks on the config bank top-level ports
`timescale 1ns/100ps
`default_nettype none
module tcsb_bank_asserts (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_en,
    input wire logic o_so,
    input wire logic o_rx_mode_select,
    input wire logic [1:0] o_baseband_bandwidth,
    input wire logic [1:0] o_tx_power_level,
    input wire logic o_tx_prefilter_enable,
    input wire logic o_tx_edge_time,
    input wire logic [1:0] o_band_select,
    input wire logic [2:0] o_fsk_deviation,
    input wire logic [2:0] o_bit_rate_select,
    input wire logic signed [15:0] o_lo_offset,
    input wire logic o_band_invalid,
    input wire logic o_rate_invalid,
    input wire logic [7:0] o_rx_tx_params_0,
    input wire logic [7:0] o_synth_other
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // byte0 fields are plain slices of the live byte
    property p_byte0;
        o_rx_mode_select == o_rx_tx_params_0[7] && o_baseband_bandwidth == o_rx_tx_params_0[3:2]
            && o_tx_power_level == o_rx_tx_params_0[1:0];
    endproperty
    a_byte0: assert property (p_byte0) else $error("byte0 field mismatch");
    property p_band_inv;
        o_band_invalid == (o_band_select == 2'h0);
    endproperty
    a_band_inv: assert property (p_band_inv) else $error("band invalid flag wrong");
    property p_rate_inv;
        o_rate_invalid == (o_bit_rate_select > 3'h4);
    endproperty
    a_rate_inv: assert property (p_rate_inv) else $error("rate invalid flag wrong");
    property p_edge;
        o_tx_edge_time |-> o_tx_prefilter_enable;
    endproperty
    a_edge: assert property (p_edge) else $error("edge time without prefilter");
    // settings must not move while enable is held low
    property p_hold;
        (!i_en) [*6] |=> $stable(o_lo_offset) && $stable(o_rx_tx_params_0);
    endproperty
    a_hold: assert property (p_hold) else $error("live setting moved while staged");
    // the sync delay is a few cycles, eight gives margin
    property p_commit;
        $rose(i_en) |-> ##8 {o_band_select, o_fsk_deviation, o_bit_rate_select} == o_synth_other;
    endproperty
    a_commit: assert property (p_commit) else $error("staged byte not applied");
    property p_so_idle;
        i_en [*8] |-> !o_so;
    endproperty
    a_so_idle: assert property (p_so_idle) else $error("serial out high outside read");
    property p_reset;
        $fell(i_srst) |-> o_band_select == 2'h1 && o_lo_offset == 16'sh0000
            && o_rx_tx_params_0 == 8'h00;
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule : tcsb_bank_asserts
bind tcsb_bank tcsb_bank_asserts i_tcsb_bank_asserts (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_en(i_en), .o_so(o_so), .o_rx_mode_select(o_rx_mode_select),
    .o_baseband_bandwidth(o_baseband_bandwidth), .o_tx_power_level(o_tx_power_level),
    .o_tx_prefilter_enable(o_tx_prefilter_enable), .o_tx_edge_time(o_tx_edge_time),
    .o_band_select(o_band_select), .o_fsk_deviation(o_fsk_deviation),
    .o_bit_rate_select(o_bit_rate_select), .o_lo_offset(o_lo_offset),
    .o_band_invalid(o_band_invalid), .o_rate_invalid(o_rate_invalid),
    .o_rx_tx_params_0(o_rx_tx_params_0), .o_synth_other(o_synth_other));
`default_nettype wire

// file: tcsb_bank_tb.sv
// self-checking bench for the config bank with a serial host model
`timescale 1ns/100ps
`default_nettype none
module tcsb_bank_tb;
    logic clk, srst, ce, sck, si, en, so, rd_valid, snap, act, pre, fsrc, edg, inh, rng, cko, rf;
    logic wk, rxm, binv, rinv;
    logic [1:0] lvl, corr, band, bbw, txp;
    logic [2:0] dev, rate;
    logic [7:0] cnt, rd_data, d, rx0, syn;
    logic [15:0] lo;
    logic [31:0] live, live2;
    logic [31:0] exp_q[$]; // oldest expectation first
    logic [7:0] stg [0:4]; // staged byte model
    logic [7:0] lm [0:4]; // live byte model
    int errors, n_tests, seed;
    assign live = {lo, band, dev, rate, rf, wk, pre, fsrc, edg, inh, rng, cko};
    // byte0 fields, validity flags and the staged byte2 view
    assign live2 = {8'h00, rx0, syn, rxm, bbw, txp, binv, rinv, 1'b0};
    tcsb_bank i_tcsb_bank (.i_clk_sys(clk), .i_srst(srst), .i_ce(ce), .i_sck(sck), .i_si(si),
        .i_en(en), .o_so(so), .i_strength_level(lvl), .i_freq_error_count(cnt),
        .i_freq_error_corr(corr), .i_strength_active(act), .o_rx_mode_select(rxm),
        .o_baseband_bandwidth(bbw), .o_tx_power_level(txp), .o_ref_source_select(rf),
        .o_rx_wakeup_type(wk), .o_tx_prefilter_enable(pre), .o_freq_error_source(fsrc),
        .o_tx_edge_time(edg), .o_tx_modulation_inhibit(inh), .o_strength_range(rng),
        .o_clock_out_enable(cko), .o_band_select(band), .o_fsk_deviation(dev),
        .o_bit_rate_select(rate), .o_lo_offset(lo), .o_band_invalid(binv),
        .o_rate_invalid(rinv), .o_rx_tx_params_0(rx0), .o_synth_other(syn));
    tcsb_host i_tcsb_host (.i_clk_sys(clk), .i_so(so), .o_sck(sck), .o_si(si), .o_en(en),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data));
    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // one comparison, counted; case inequality so unknowns fail
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check
    task automatic finish_test();
        if (exp_q.size() != 0) errors++; // a noted result that never showed up
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // expected status byte from the live error source and the result inputs
    function automatic logic [7:0] stat_exp();
        logic [7:0] e;
        e = lm[1][4] ? {2'b00, corr, 4'h0} : cnt;
        if (act) e[7:6] = lvl;
        return e;
    endfunction : stat_exp
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        i_tcsb_host.frame(1'b0, a, v, 1'b0);
        if (a < 5'h05) stg[a] = v;
    endtask : wr
    // reads show live values; unmapped places read zero
    task automatic rd(input logic [4:0] a);
        exp_q.push_back({24'h0, a < 5'h05 ? lm[a] : (a == 5'h05 ? stat_exp() : 8'h00)});
        i_tcsb_host.frame(1'b1, a, 8'h00, 1'b0);
    endtask : rd
    task automatic commit();
        i_tcsb_host.commit();
        lm = stg;
    endtask : commit
    // note the expected decoded outputs and pulse the snapshot strobe
    task automatic snap_live();
        exp_q.push_back({lm[3], lm[4], lm[2], lm[1][7:4], lm[1][3] & lm[1][5], lm[1][2:0]});
        exp_q.push_back({8'h00, lm[0], stg[2], lm[0][7], lm[0][3:2], lm[0][1:0],
            lm[2][7:6] == 2'h0, lm[2][2:0] > 3'h4, 1'b0});
        snap = 1'b1;
        @(posedge clk);
        #1 snap = 1'b0;
    endtask : snap_live
    // monitor: every result takes the oldest note off the queue
    always @(posedge clk) begin
        if (rd_valid) check({24'h0, rd_data}, exp_q.pop_front());
        if (snap) check(live, exp_q.pop_front());
        if (snap) check(live2, exp_q.pop_front());
    end
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        finish_test();
    end
    initial begin
        seed = 66;
        {srst, ce, snap, act, lvl, corr, cnt} = {3'b110, 13'h0};
        stg = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
        lm = stg;
        repeat (12) @(posedge clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge clk);
        #1 cnt = 8'($random(seed));
        for (int a = 0; a < 6; a++) rd(5'(a));
        snap_live();
        // new values stay staged until enable rises
        for (int a = 0; a < 6; a++) wr(5'(a), 8'($random(seed)));
        for (int a = 0; a < 6; a++) rd(5'(a));
        commit();
        snap_live();
        for (int a = 0; a < 5; a++) rd(5'(a));
        // spoiled stop bit drops the frame
        i_tcsb_host.frame(1'b0, 5'h00, ~lm[0], 1'b1);
        commit();
        rd(5'h00);
        // every status layout with random results
        for (int m = 0; m < 4; m++) begin
            d = 8'($random(seed));
            d[4] = m[0];
            wr(5'h01, d);
            commit();
            {act, lvl, corr, cnt} = {m[1], 12'($random(seed))};
            rd(5'h05);
            snap_live();
        end
        // a frozen clock enable holds the commit back until it runs again
        wr(5'h04, 8'($random(seed)));
        ce = 1'b0;
        i_tcsb_host.commit();
        snap_live();
        ce = 1'b1;
        repeat (6) @(posedge clk);
        #1 lm = stg;
        snap_live();
        // places beyond the bank ignore writes and read zero
        wr(5'h06, 8'hFF);
        wr(5'h1F, 8'hA5);
        commit();
        rd(5'h06);
        rd(5'h1F);
        snap_live();
        finish_test();
    end
endmodule : tcsb_bank_tb
`default_nettype wire
